// [rtl/rie_defines.vh]
// rie_defines.vh: register offsets, field positions and reset values
// of the radio interrupt-enable block.
// assumes: included by bare name from the rtl/ files, Verilog-2005.
`ifndef RIE_DEFINES_VH
`define RIE_DEFINES_VH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define RIE_OFS_EVENT_STATUS 12'h100
`define RIE_OFS_INT_SET 12'h304
`define RIE_OFS_INT_CLEAR 12'h308
`define RIE_OFS_INT_PENDING 12'h30C

// ********************************************************************
// event bit positions, shared by all four registers
// ********************************************************************
`define RIE_BIT_READY 0
`define RIE_BIT_ADDRESS 1
`define RIE_BIT_PAYLOAD 2
`define RIE_BIT_END 3
`define RIE_BIT_DISABLED 4
`define RIE_BIT_DEV_HIT 5
`define RIE_BIT_DEV_FAIL 6
`define RIE_BIT_SIG_DONE 7
`define RIE_BIT_BC_HIT 10
`define RIE_BIT_CHECK_PASS 12
`define RIE_BIT_CHECK_FAIL 13
`define RIE_BIT_TX_READY 21
`define RIE_BIT_RX_READY 22
`define RIE_BIT_HDR_MATCH 23
`define RIE_BIT_PHY_END 27

// ********************************************************************
// reset values and implemented-bit mask
// ********************************************************************
`define RIE_RST_INT_ENABLE 32'h00000000
`define RIE_RST_EVENT_STATUS 32'h00000000
`define RIE_VALID_MASK 32'h08E034FF

`endif

// [rtl/rie_sticky.v]
// rie_sticky.v: bank of sticky bits, set and clear per bit.
// assumes: set and clear come from logic on clk_sys.
`timescale 1ns/1ps
module rie_sticky #(
  parameter WIDTH = 32,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] KEEP_MASK = {WIDTH{1'b1}}
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [WIDTH-1:0] set_bits,
  input wire [WIDTH-1:0] clear_bits,
  output wire [WIDTH-1:0] value
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      if (KEEP_MASK[i]) begin : g_live
        reg bit_q;
        always @(posedge clk_sys) begin
          if (sys_rst) begin
            bit_q <= RESET_VALUE[i];
          end else if (set_bits[i]) begin
            // set beats a clear in the same cycle so no event is lost
            bit_q <= 1'b1;
          end else if (clear_bits[i]) begin
            bit_q <= 1'b0;
          end
        end
        assign value[i] = bit_q;
      end else begin : g_dead
        assign value[i] = 1'b0;
      end
    end
  endgenerate
endmodule // rie_sticky

// [rtl/rie_irq_gate.v]
// rie_irq_gate.v: registered OR of enabled pending events.
// assumes: status and enable are on clk_sys.
`timescale 1ns/1ps
module rie_irq_gate #(
  parameter WIDTH = 32
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [WIDTH-1:0] status,
  input wire [WIDTH-1:0] enable,
  output wire [WIDTH-1:0] pending,
  output reg irq
);
  assign pending = status & enable;
  // registered so the line towards the core is glitch free
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |pending;
    end
  end
endmodule // rie_irq_gate

// [rtl/rie_top.v]
// rie_top.v: interrupt enable set/clear registers of the radio, with
// sticky event flags and the level interrupt they raise.
// assumes: APB master and radio event pulses on clk_sys, sync reset.
//
// Functional notes
// R01: 32-bit enable-set register at 0x304, one bit per radio event.
// R02: writing 1 to ready, address, payload bits sets their enables.
// R03: writing 1 to end or disabled bits sets their enables.
// R04: writing 1 to device hit or fail bits sets their enables.
// R05: writing 1 to signal-strength-done bit sets its enable.
// R06: writing 1 to bit-counter-hit bit sets its enable.
// R07: writing 1 to check pass or check fail bits sets their enables.
// R08: writing 1 to transmit or receive path ready bits sets enables.
// R09: writing 1 to header match or physical end bits sets enables.
// R10: clear register at 0x308 clears enables on 1, reads same state.
// R11: physical end event is a source this enable gates.
// R12: reads show enables; zero after reset; undefined bits read zero.
// R13: zeros written do nothing; interrupt while enabled flag is set.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "rie_defines.vh"
module rie_top (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ev_ready,
  input wire ev_address,
  input wire ev_payload,
  input wire ev_end,
  input wire ev_disabled,
  input wire ev_device_address_hit,
  input wire ev_device_address_fail,
  input wire ev_signal_strength_done,
  input wire ev_bit_counter_hit,
  input wire ev_check_pass_event,
  input wire ev_check_fail_event,
  input wire ev_transmit_path_ready,
  input wire ev_receive_path_ready,
  input wire ev_header_match_event,
  input wire ev_physical_end_event,
  output wire irq
);

  // ******************************************************************
  // decode
  // ******************************************************************
  wire [31:0] interrupt_enable;
  wire [31:0] event_status;
  wire [31:0] pending;
  wire [31:0] event_in;
  wire [31:0] byte_mask;
  wire [31:0] wr_bits;
  wire hit_status;
  wire hit_set;
  wire hit_clear;
  wire hit_pending;
  wire mapped;
  wire wr_go;
  reg [31:0] next_prdata;

  assign hit_status = (paddr == `RIE_OFS_EVENT_STATUS);
  assign hit_set = (paddr == `RIE_OFS_INT_SET); // see R01
  assign hit_clear = (paddr == `RIE_OFS_INT_CLEAR); // see R10
  assign hit_pending = (paddr == `RIE_OFS_INT_PENDING);
  assign mapped = hit_status | hit_set | hit_clear | hit_pending;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_go = psel & penable & pwrite & mapped;

  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};
  // only ones in enabled lanes act; zeros never touch state
  assign wr_bits = pwdata & byte_mask & `RIE_VALID_MASK; // see R13

  // ******************************************************************
  // event sources
  // ******************************************************************
  assign event_in[`RIE_BIT_READY] = ev_ready;
  assign event_in[`RIE_BIT_ADDRESS] = ev_address;
  assign event_in[`RIE_BIT_PAYLOAD] = ev_payload;
  assign event_in[`RIE_BIT_END] = ev_end;
  assign event_in[`RIE_BIT_DISABLED] = ev_disabled;
  assign event_in[`RIE_BIT_DEV_HIT] = ev_device_address_hit;
  assign event_in[`RIE_BIT_DEV_FAIL] = ev_device_address_fail;
  assign event_in[`RIE_BIT_SIG_DONE] = ev_signal_strength_done;
  assign event_in[9:8] = 2'h0;
  assign event_in[`RIE_BIT_BC_HIT] = ev_bit_counter_hit;
  assign event_in[11] = 1'b0;
  assign event_in[`RIE_BIT_CHECK_PASS] = ev_check_pass_event;
  assign event_in[`RIE_BIT_CHECK_FAIL] = ev_check_fail_event;
  assign event_in[20:14] = 7'h00;
  assign event_in[`RIE_BIT_TX_READY] = ev_transmit_path_ready;
  assign event_in[`RIE_BIT_RX_READY] = ev_receive_path_ready;
  assign event_in[`RIE_BIT_HDR_MATCH] = ev_header_match_event;
  assign event_in[26:24] = 3'h0;
  assign event_in[`RIE_BIT_PHY_END] = ev_physical_end_event; // see R11
  assign event_in[31:28] = 4'h0;

  // ******************************************************************
  // enable bits: set via 0x304, clear via 0x308
  // ******************************************************************
  // set and clear share one flop per implemented bit; every such bit is set the same way
  // see R02 see R03 see R04 see R05 see R06 see R07 see R08 see R09
  rie_sticky #(
    .WIDTH(32),
    .RESET_VALUE(`RIE_RST_INT_ENABLE),
    .KEEP_MASK(`RIE_VALID_MASK)
  ) u_enable (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set_bits(wr_go & hit_set ? wr_bits : 32'h00000000),
    .clear_bits(wr_go & hit_clear ? wr_bits : 32'h00000000), // see R10
    .value(interrupt_enable)
  );

  // ******************************************************************
  // sticky event flags, write one to clear
  // ******************************************************************
  rie_sticky #(
    .WIDTH(32),
    .RESET_VALUE(`RIE_RST_EVENT_STATUS),
    .KEEP_MASK(`RIE_VALID_MASK)
  ) u_status (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set_bits(event_in),
    .clear_bits(wr_go & hit_status ? wr_bits : 32'h00000000),
    .value(event_status)
  );

  // ******************************************************************
  // interrupt
  // ******************************************************************
  rie_irq_gate #(
    .WIDTH(32)
  ) u_irq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .status(event_status),
    .enable(interrupt_enable),
    .pending(pending),
    .irq(irq) // see R13
  );

  // ******************************************************************
  // read data, captured in the setup phase
  // ******************************************************************
  always @* begin
    next_prdata = 32'h00000000;
    if (hit_set | hit_clear) begin
      next_prdata = interrupt_enable; // see R12
    end else if (hit_status) begin
      next_prdata = event_status;
    end else if (hit_pending) begin
      next_prdata = pending;
    end
  end

  // sampled at setup so prdata is a flop and still zero wait
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule // rie_top

// [bench/rie_top_asserts.sv]
// rie_top_asserts.sv: port checker for rie_top, bound below.
// assumes: one clock, synchronous active-high reset.
`timescale 1ns/1ps
`include "rie_defines.vh"
module rie_top_asserts (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq
);
  localparam logic [31:0] M = `RIE_VALID_MASK;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rdx = acc && !pwrite;
  wire hit = paddr == 12'h100 || paddr == 12'h304 ||
    paddr == 12'h308 || paddr == 12'h30C;
  // full clear leaves nothing able to hold irq up
  wire clr = wr && paddr == 12'h308 && pwdata == 32'hFFFFFFFF &&
    pstrb == 4'hF;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  rdy_high_a: assert property (pready)
    else $error("pready low");
  err_map_a: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped access");
  err_only_a: assert property (pslverr |-> acc && !hit)
    else $error("stray error");
  rd_mask_a: assert property (rdx |-> (prdata & ~M) == 0)
    else $error("undefined bit reads one");
  rd_unmap_a: assert property (rdx && !hit |-> !prdata)
    else $error("unmapped read not zero");
  rst_clean_a: assert property ($fell(sys_rst) |-> !irq && !prdata)
    else $error("outputs not clear after reset");
  clr_all_a: assert property (clr |-> ##2 !irq)
    else $error("irq stays after full clear");
  irq_fall_a: assert property (
    $fell(irq) && !$past(sys_rst) |-> $past(wr, 2))
    else $error("irq fell without a write");
endmodule // rie_top_asserts
bind rie_top rie_top_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// [bench/rie_top_tb.sv]
// rie_top_tb.sv: self-checking random bench for rie_top.
// assumes: design and checker compiled first, 100 MHz clock.
`timescale 1ns/1ps
`include "rie_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module rie_top_tb;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, ev = 0, prdata, rd, en, d;
  logic [3:0] pstrb = 0, s;
  logic pready, pslverr, irq;
  int fail_count = 0, n_checks = 0, b;
  int bits[15] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 12, 13, 21, 22, 23, 27};
  logic [11:0] addrs[4] = '{12'h100, 12'h304, 12'h308, 12'h30C};
  always #5 clk_sys = ~clk_sys;
  rie_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_ready(ev[0]), .ev_address(ev[1]), .ev_payload(ev[2]),
    .ev_end(ev[3]), .ev_disabled(ev[4]), .ev_device_address_hit(ev[5]),
    .ev_device_address_fail(ev[6]), .ev_signal_strength_done(ev[7]),
    .ev_bit_counter_hit(ev[10]), .ev_check_pass_event(ev[12]),
    .ev_check_fail_event(ev[13]), .ev_transmit_path_ready(ev[21]),
    .ev_receive_path_ready(ev[22]), .ev_header_match_event(ev[23]),
    .ev_physical_end_event(ev[27]), .irq(irq));
  // ********
  // bus cycle and helpers
  // ********
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, input logic [3:0] st);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] lanes(input logic [3:0] st);
    return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction
  // irq lags its cause by two edges; three leaves margin
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude;
  end
  initial begin
    void'($urandom(34));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 0;
    en = 0;
    foreach (addrs[i]) begin
      apb(0, addrs[i], 0, 0);
      `CHK(rd, 32'h00000000)
    end
    $display("test reset done");
    foreach (bits[i]) begin
      apb(1, 12'h304, 32'h1 << bits[i], 4'hF);
      en[bits[i]] = 1;
      apb(0, 12'h304, 0, 0);
      `CHK(rd, en)
      apb(0, 12'h308, 0, 0);
      `CHK(rd, en)
    end
    apb(1, 12'h304, 32'hFFFFFFFF, 4'hF);
    apb(1, 12'h304, 32'h00000000, 4'hF);
    apb(0, 12'h304, 0, 0);
    `CHK(rd, `RIE_VALID_MASK)
    $display("test set bits done");
    repeat (40) begin
      d = $urandom;
      s = 4'($urandom);
      b = $urandom % 2;
      apb(1, b ? 12'h304 : 12'h308, d, s);
      en = b ? en | (d & lanes(s) & `RIE_VALID_MASK) : en & ~(d & lanes(s));
      apb(0, 12'h304, 0, 0);
      `CHK(rd, en)
    end
    $display("test random done");
    apb(1, 12'h200, 32'hFFFFFFFF, 4'hF);
    `CHK(err, 1'b1)
    apb(0, 12'h200, 0, 0);
    `CHK({err, rd}, {1'b1, 32'h00000000})
    apb(0, 12'h304, 0, 0);
    `CHK({err, rd}, {1'b0, en})
    $display("test unmapped done");
    apb(1, 12'h308, 32'hFFFFFFFF, 4'hF);
    foreach (bits[i]) begin
      @(posedge clk_sys);
      ev <= 32'h1 << bits[i];
      @(posedge clk_sys);
      ev <= 0;
      settle;
      `CHK(irq, 1'b0)
      apb(0, 12'h100, 0, 0);
      `CHK(rd, 32'h1 << bits[i])
      apb(1, 12'h304, 32'h1 << bits[i], 4'hF);
      settle;
      `CHK(irq, 1'b1)
      apb(0, 12'h30C, 0, 0);
      `CHK(rd, 32'h1 << bits[i])
      apb(1, 12'h308, 32'h1 << bits[i], 4'hF);
      settle;
      `CHK(irq, 1'b0)
      apb(1, 12'h304, 32'h1 << bits[i], 4'hF);
      apb(1, 12'h100, 32'hFFFFFFFF, 4'hF);
      settle;
      `CHK(irq, 1'b0)
      apb(1, 12'h308, 32'hFFFFFFFF, 4'hF);
    end
    $display("test events done");
    conclude;
  end
endmodule // rie_top_tb
